// ---- inc/oas_defines.vh ----
// Purpose: Constants for the operand address and exception sequencer.
// Assumes: Included by bare name from the design files.
// Notes: Definitions only; no logic.
// Behaviour
// RQ1: Taken branch adds sign-extended 8-bit displacement to the program counter.
// RQ2: Immediate operand follows opcode; 16-bit value is high byte first.
// RQ3: Direct mode prefixes a zero high byte to the 8-bit address.
// RQ4: Extended mode takes the 16-bit address from two bytes, high first.
// RQ5: Plain indexed mode uses the index pair as the address.
// RQ6: Plain indexed post-increment adds one to the index pair after the read.
// RQ7: Indexed 8-bit offset adds an unsigned byte to the index pair.
// RQ8: Indexed 8-bit offset post-increment bumps the index pair after the read.
// RQ9: Indexed 16-bit offset adds a 16-bit offset to the index pair.
// RQ10: Stack modes add an unsigned 8-bit or 16-bit offset to the stack pointer.
// RQ11: The selected 16 KB page appears in the 0x8000 to 0xBFFF window.
// RQ12: Far call stacks return address and page; far return restores both.
// RQ13: Test-and-branch ops fetch the operand by mode, target always relative; code skips the displacement read in INH and IMM modes.
// RQ14: Any reset abandons current activity at once.
// RQ15: After reset, six cycles fetch the vector at 0xFFFE/0xFFFF and fill queue.
// RQ16: Interrupts wait for instruction end, then take the highest pending one.
// RQ17: Entry pushes PC low, PC high, X, A, condition codes, then sets the mask.
// RQ18: Then vector high, vector low, one free cycle, three queue fill reads.
// RQ19: Entry never pushes the high byte of the index pair.
// RQ20: Software interrupt runs the same entry, ignoring the mask, at its opcode.
// RQ21: Wait clears the mask, stops clocks until interrupt or reset.
// RQ22: Debug background command during wait restarts clocks into background mode.
// RQ23: While mask bit 3 is set, maskable interrupts are ignored.
// RQ24: Address sums and post-increments wrap modulo 16 bits.
`ifndef OAS_DEFINES_VH
`define OAS_DEFINES_VH

`define OAS_RESET_VEC 16'hfffe
`define OAS_SWI_VEC 16'hfffc
`define OAS_IRQ_VEC_TOP 16'hfffa
`define OAS_SP_RESET 16'h00ff
`define OAS_HX_RESET 16'h0000
`define OAS_PAGE_RESET 8'h00
`define OAS_IMASK_BIT 3
`define OAS_FILL_BYTES 3'h3
`define OAS_WIN_TAG 2'h2

`define OAS_M_INH 4'h0
`define OAS_M_REL 4'h1
`define OAS_M_IMM 4'h2
`define OAS_M_DIR 4'h3
`define OAS_M_EXT 4'h4
`define OAS_M_IX 4'h5
`define OAS_M_IXP 4'h6
`define OAS_M_IX1 4'h7
`define OAS_M_IX1P 4'h8
`define OAS_M_IX2 4'h9
`define OAS_M_SP1 4'ha
`define OAS_M_SP2 4'hb

`define OAS_OP_EA 3'h0
`define OAS_OP_BRANCH 3'h1
`define OAS_OP_CALL 3'h2
`define OAS_OP_RTC 3'h3
`define OAS_OP_SWI 3'h4
`define OAS_OP_WAIT 3'h5

`endif

// ---- core/oas_ea_calc.v ----
// Purpose: Effective address of an operand from mode, operand bytes and bases.
// Assumes: Operand bytes already collected, first byte in the upper half.
// Notes: Purely combinational; all sums wrap in 16 bits.
`timescale 1ns/1ps
`default_nettype none
`include "oas_defines.vh"
module oas_ea_calc (
  input wire [3:0] mode,
  input wire [15:0] opnd,
  input wire [15:0] index_pair,
  input wire [15:0] stack_pointer,
  input wire [15:0] pc,
  output reg [15:0] ea
);
  always @* begin
    case (mode)
      `OAS_M_REL: ea = pc + {{8{opnd[7]}}, opnd[7:0]}; // RQ1 RQ24
      `OAS_M_IMM: ea = pc; // RQ2
      `OAS_M_DIR: ea = {8'h00, opnd[7:0]}; // RQ3
      `OAS_M_EXT: ea = opnd; // RQ4
      `OAS_M_IX, `OAS_M_IXP: ea = index_pair; // RQ5 RQ6
      `OAS_M_IX1, `OAS_M_IX1P: ea = index_pair + {8'h00, opnd[7:0]}; // RQ7 RQ8 RQ24
      `OAS_M_IX2: ea = index_pair + opnd; // RQ9 RQ24
      `OAS_M_SP1: ea = stack_pointer + {8'h00, opnd[7:0]}; // RQ10 RQ24
      `OAS_M_SP2: ea = stack_pointer + opnd; // RQ10 RQ24
      default: ea = 16'h0000;
    endcase
  end
endmodule // oas_ea_calc
`default_nettype wire

// ---- core/oas_seq.v ----
// Purpose: Operand address generation, far call/return, reset, interrupt,
//   wait and background entry sequencing for the 8-bit CPU.
// Assumes: Memory returns read data one cycle after mem_rd; all inputs are
//   from logic on clk; rst already merges power-on, watchdog and pin resets.
// Notes: Instruction decode and ALU live outside; this block owns PC, SP,
//   index pair, page select and the interrupt mask.
`timescale 1ns/1ps
`default_nettype none
`include "oas_defines.vh"
module oas_seq #(
  parameter IRQ_N = 8
) (
  input wire clk,
  input wire rst,
  input wire cmd_valid,
  input wire [2:0] cmd_op,
  input wire [3:0] cmd_mode,
  input wire cmd_wide,
  input wire cmd_rel,
  input wire cmd_cond,
  input wire [IRQ_N-1:0] irq_req,
  input wire dbg_bgnd_req,
  input wire dbg_go,
  input wire [7:0] acc,
  input wire [7:0] flags,
  input wire reg_wr_hx,
  input wire reg_wr_sp,
  input wire reg_wr_ccr,
  input wire [15:0] reg_wdata,
  input wire [7:0] mem_rdata,
  output wire cmd_ready,
  output reg op_done,
  output reg [15:0] eff_addr,
  output reg [15:0] operand,
  output reg [15:0] branch_target,
  output reg [15:0] pc,
  output reg [15:0] index_pair,
  output reg [15:0] stack_pointer,
  output reg [7:0] program_page_select,
  output reg cond_imask,
  output reg [15:0] mem_addr,
  output reg mem_rd,
  output reg mem_wr,
  output reg [7:0] mem_wdata,
  output wire mem_win,
  output reg qfill,
  output wire cpu_clk_en,
  output wire bgnd_active
);
  // ---------------------------------------------------------------
  // States and helpers
  // ---------------------------------------------------------------
  localparam [4:0] S_V0 = 5'h00;
  localparam [4:0] S_V1 = 5'h01;
  localparam [4:0] S_V2 = 5'h02;
  localparam [4:0] S_FILL = 5'h03;
  localparam [4:0] S_IDLE = 5'h04;
  localparam [4:0] S_FETCH = 5'h05;
  localparam [4:0] S_CAP = 5'h06;
  localparam [4:0] S_EXEC = 5'h07;
  localparam [4:0] S_OPRD = 5'h08;
  localparam [4:0] S_OPCAP = 5'h09;
  localparam [4:0] S_RELRD = 5'h0a;
  localparam [4:0] S_RELCAP = 5'h0b;
  localparam [4:0] S_PUSH = 5'h0c;
  localparam [4:0] S_PULL = 5'h0d;
  localparam [4:0] S_PCAP = 5'h0e;
  localparam [4:0] S_WAIT = 5'h0f;
  localparam [4:0] S_BGND = 5'h10;

  reg [4:0] state;
  reg [2:0] cnt;
  reg [1:0] nbytes;
  reg push_call;
  reg [23:0] opnd;
  reg [15:0] vec;
  reg [2:0] op;
  reg [3:0] mode;
  reg wide;
  reg mode_relative;
  reg cond;
  reg [7:0] push_byte;
  wire [15:0] ea_w;
  wire irq_pend;
  wire [7:0] ccr_out;

  function [1:0] byte_count;
    input [3:0] m;
    input w;
    begin
      case (m)
        `OAS_M_INH, `OAS_M_IX, `OAS_M_IXP: byte_count = 2'd0;
        `OAS_M_IMM: byte_count = w ? 2'd2 : 2'd1;
        `OAS_M_EXT, `OAS_M_IX2, `OAS_M_SP2: byte_count = 2'd2;
        default: byte_count = 2'd1;
      endcase
    end
  endfunction

  function [15:0] rel_target;
    input [15:0] base;
    input [7:0] disp;
    begin
      rel_target = base + {{8{disp[7]}}, disp};
    end
  endfunction

  // Lowest request index has the highest priority
  function [7:0] prio_vec_off;
    input [IRQ_N-1:0] r;
    integer i;
    begin
      prio_vec_off = 8'h00;
      for (i = IRQ_N - 1; i >= 0; i = i - 1) begin
        if (r[i]) begin
          prio_vec_off = i[6:0] << 1;
        end
      end
    end
  endfunction

  // Maskable requests count only while the mask is clear
  assign irq_pend = (|irq_req) & ~cond_imask; // RQ23
  assign cmd_ready = (state == S_IDLE) & ~irq_pend;
  // Clocks stay stopped only while waiting; background mode runs them
  assign cpu_clk_en = (state != S_WAIT); // RQ21 RQ22
  assign bgnd_active = (state == S_BGND);
  // Addresses with top bits 10 fall into the paged program window
  assign mem_win = (mem_addr[15:14] == `OAS_WIN_TAG); // RQ11
  assign ccr_out = {flags[7:4], cond_imask, flags[2:0]};

  oas_ea_calc u_ea (
    .mode(mode),
    .opnd(opnd[15:0]),
    .index_pair(index_pair),
    .stack_pointer(stack_pointer),
    .pc(pc),
    .ea(ea_w)
  );

  // ---------------------------------------------------------------
  // Stacking order
  // ---------------------------------------------------------------
  // The high byte of the index pair is never offered for stacking
  always @* begin
    push_byte = 8'h00;
    case (cnt)
      3'd0: push_byte = pc[7:0]; // RQ17 RQ12
      3'd1: push_byte = pc[15:8]; // RQ17 RQ12
      3'd2: push_byte = push_call ? program_page_select : index_pair[7:0]; // RQ12 RQ19
      3'd3: push_byte = acc; // RQ17
      3'd4: push_byte = ccr_out; // RQ17
      default: push_byte = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin // RQ14
      state <= S_V0;
      vec <= `OAS_RESET_VEC; // RQ15
      cnt <= 3'd0;
      nbytes <= 2'd0;
      push_call <= 1'b0;
      opnd <= 24'h000000;
      op <= `OAS_OP_EA;
      mode <= `OAS_M_INH;
      wide <= 1'b0;
      mode_relative <= 1'b0;
      cond <= 1'b0;
      op_done <= 1'b0;
      eff_addr <= 16'h0000;
      operand <= 16'h0000;
      branch_target <= 16'h0000;
      pc <= 16'h0000;
      index_pair <= `OAS_HX_RESET;
      stack_pointer <= `OAS_SP_RESET;
      program_page_select <= `OAS_PAGE_RESET;
      cond_imask <= 1'b1;
      mem_addr <= 16'h0000;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_wdata <= 8'h00;
      qfill <= 1'b0;
    end else begin
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      qfill <= 1'b0;
      op_done <= 1'b0;
      if (reg_wr_hx) begin
        index_pair <= reg_wdata;
      end
      if (reg_wr_sp) begin
        stack_pointer <= reg_wdata;
      end
      if (reg_wr_ccr) begin
        cond_imask <= reg_wdata[`OAS_IMASK_BIT];
      end
      case (state)
        // Vector high, vector low, then a free cycle with no access
        S_V0: begin
          mem_addr <= vec; // RQ15 RQ18
          mem_rd <= 1'b1;
          state <= S_V1;
        end
        S_V1: begin
          opnd[7:0] <= mem_rdata;
          mem_addr <= vec + 16'h0001; // RQ15 RQ18
          mem_rd <= 1'b1;
          state <= S_V2;
        end
        S_V2: begin
          pc <= {opnd[7:0], mem_rdata}; // RQ18
          cnt <= 3'd0;
          state <= S_FILL;
        end
        S_FILL: begin
          mem_addr <= pc + {13'h0000, cnt}; // RQ15 RQ18
          mem_rd <= 1'b1;
          qfill <= 1'b1;
          cnt <= cnt + 3'd1;
          if (cnt == `OAS_FILL_BYTES - 3'd1) begin
            op_done <= 1'b1;
            state <= S_IDLE;
          end
        end
        // Interrupts are looked at only between instructions
        S_IDLE: begin
          if (irq_pend) begin // RQ16 RQ23
            vec <= `OAS_IRQ_VEC_TOP - {8'h00, prio_vec_off(irq_req)}; // RQ16
            push_call <= 1'b0;
            cnt <= 3'd0;
            state <= S_PUSH;
          end else if (cmd_valid) begin
            op <= cmd_op;
            mode <= cmd_mode;
            wide <= cmd_wide;
            mode_relative <= cmd_rel;
            cond <= cmd_cond;
            opnd <= 24'h000000;
            cnt <= 3'd0;
            case (cmd_op)
              `OAS_OP_EA: begin
                nbytes <= byte_count(cmd_mode, cmd_wide);
                state <= S_FETCH;
              end
              `OAS_OP_BRANCH: begin
                nbytes <= 2'd1;
                state <= S_FETCH;
              end
              `OAS_OP_CALL: begin
                nbytes <= 2'd3;
                state <= S_FETCH;
              end
              `OAS_OP_RTC: state <= S_PULL;
              `OAS_OP_SWI: begin
                vec <= `OAS_SWI_VEC; // RQ20
                push_call <= 1'b0;
                state <= S_PUSH;
              end
              `OAS_OP_WAIT: begin
                cond_imask <= 1'b0; // RQ21
                state <= S_WAIT;
              end
              default: op_done <= 1'b1;
            endcase
          end
        end
        S_FETCH: begin
          if (cnt[1:0] == nbytes) begin
            state <= S_EXEC;
          end else begin
            mem_addr <= pc;
            mem_rd <= 1'b1;
            pc <= pc + 16'h0001;
            state <= S_CAP;
          end
        end
        S_CAP: begin
          opnd <= {opnd[15:0], mem_rdata}; // RQ2 RQ4
          cnt <= cnt + 3'd1;
          state <= S_FETCH;
        end
        S_EXEC: begin
          cnt <= 3'd0;
          case (op)
            `OAS_OP_BRANCH: begin
              branch_target <= rel_target(pc, opnd[7:0]); // RQ1
              if (cond) begin
                pc <= rel_target(pc, opnd[7:0]); // RQ1
                state <= S_FILL;
              end else begin
                op_done <= 1'b1;
                state <= S_IDLE;
              end
            end
            `OAS_OP_CALL: begin
              push_call <= 1'b1; // RQ12
              state <= S_PUSH;
            end
            default: begin
              eff_addr <= ea_w;
              if (mode == `OAS_M_IMM) begin
                operand <= wide ? opnd[15:0] : {8'h00, opnd[7:0]}; // RQ2
              end
              if (mode == `OAS_M_INH || mode == `OAS_M_REL || mode == `OAS_M_IMM) begin
                op_done <= 1'b1;
                state <= S_IDLE;
              end else begin
                state <= S_OPRD;
              end
            end
          endcase
        end
        S_OPRD: begin
          mem_addr <= eff_addr;
          mem_rd <= 1'b1;
          state <= S_OPCAP;
        end
        S_OPCAP: begin
          operand <= {8'h00, mem_rdata};
          // Increment only once the operand has been read
          if (mode == `OAS_M_IXP || mode == `OAS_M_IX1P) begin
            index_pair <= index_pair + 16'h0001; // RQ6 RQ8 RQ24
          end
          if (mode_relative) begin
            state <= S_RELRD; // RQ13
          end else begin
            op_done <= 1'b1;
            state <= S_IDLE;
          end
        end
        S_RELRD: begin
          mem_addr <= pc;
          mem_rd <= 1'b1;
          pc <= pc + 16'h0001;
          state <= S_RELCAP;
        end
        S_RELCAP: begin
          // Caller decides the condition; the target is always relative
          branch_target <= rel_target(pc, mem_rdata); // RQ13
          op_done <= 1'b1;
          state <= S_IDLE;
        end
        S_PUSH: begin
          mem_addr <= stack_pointer;
          mem_wr <= 1'b1;
          mem_wdata <= push_byte;
          stack_pointer <= stack_pointer - 16'h0001;
          cnt <= cnt + 3'd1;
          if (push_call && cnt == 3'd2) begin
            program_page_select <= opnd[7:0]; // RQ12 RQ11
            pc <= opnd[23:8];
            cnt <= 3'd0;
            state <= S_FILL;
          end else if (!push_call && cnt == 3'd4) begin
            cond_imask <= 1'b1; // RQ17
            state <= S_V0;
          end
        end
        S_PULL: begin
          mem_addr <= stack_pointer + 16'h0001;
          mem_rd <= 1'b1;
          stack_pointer <= stack_pointer + 16'h0001;
          state <= S_PCAP;
        end
        S_PCAP: begin
          opnd <= {opnd[15:0], mem_rdata};
          cnt <= cnt + 3'd1;
          if (cnt == 3'd2) begin
            program_page_select <= opnd[15:8]; // RQ12
            pc <= {opnd[7:0], mem_rdata}; // RQ12
            cnt <= 3'd0;
            state <= S_FILL;
          end else begin
            state <= S_PULL;
          end
        end
        // Any request wakes; the mask was cleared on entry
        S_WAIT: begin
          if (|irq_req) begin // RQ21
            vec <= `OAS_IRQ_VEC_TOP - {8'h00, prio_vec_off(irq_req)};
            push_call <= 1'b0;
            cnt <= 3'd0;
            state <= S_PUSH;
          end else if (dbg_bgnd_req) begin
            state <= S_BGND; // RQ22
          end
        end
        S_BGND: begin
          if (dbg_go) begin
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // oas_seq
`default_nettype wire

// ---- sim/oas_props.sv ----
// Purpose: Port-level assertions for the operand address and exception sequencer.
// Assumes: One clock; rst synchronous, active high.
// Notes: Reads at 0xfff0-0xfffd are taken as exception vector fetches.
`timescale 1ns/1ps
`default_nettype none
module oas_props #(
  parameter int IRQ_N = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [IRQ_N-1:0] irq_req,
  input wire logic dbg_bgnd_req,
  input wire logic cmd_ready,
  input wire logic op_done,
  input wire logic cond_imask,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic mem_win,
  input wire logic qfill,
  input wire logic cpu_clk_en,
  input wire logic bgnd_active
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_win;
    mem_win == (mem_addr[15:14] == 2'b10);
  endproperty
  a_win: assert property (p_win) else $error("window flag disagrees with address");
  property p_rst_idle;
    $fell(rst) |-> !mem_rd && !mem_wr && !op_done && !qfill;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("bus busy out of reset");
  property p_rst_vec;
    $fell(rst) |-> ##[1:2] (mem_rd && mem_addr == 16'hfffe) ##1 (mem_rd && mem_addr == 16'hffff)
      ##1 (!mem_rd && !mem_wr) ##1 qfill[*3];
  endproperty
  a_rst_vec: assert property (p_rst_vec) else $error("reset vector sequence wrong");
  property p_fill;
    $rose(qfill) |-> qfill[*3] ##1 !qfill;
  endproperty
  a_fill: assert property (p_fill) else $error("queue fill is not three reads");
  property p_vec_mask;
    mem_rd && mem_addr[15:4] == 12'hfff && mem_addr[3:1] != 3'h7 |-> cond_imask;
  endproperty
  a_vec_mask: assert property (p_vec_mask) else $error("vector fetched with mask clear");
  property p_unmasked;
    !cond_imask && irq_req != '0 |-> !cmd_ready;
  endproperty
  a_unmasked: assert property (p_unmasked) else $error("command accepted over interrupt");
  property p_masked;
    op_done && cond_imask |=> cmd_ready || !cpu_clk_en || bgnd_active;
  endproperty
  a_masked: assert property (p_masked) else $error("masked request blocked commands");
  property p_wake;
    !cpu_clk_en && irq_req != '0 |-> ##[1:3] cpu_clk_en;
  endproperty
  a_wake: assert property (p_wake) else $error("interrupt did not end wait");
  property p_bgnd;
    !cpu_clk_en && dbg_bgnd_req && irq_req == '0 |-> ##[1:3] bgnd_active;
  endproperty
  a_bgnd: assert property (p_bgnd) else $error("debug entry from wait missing");
endmodule // oas_props
bind oas_seq oas_props #(.IRQ_N(IRQ_N)) oas_props_i (.clk(clk), .rst(rst), .irq_req(irq_req),
  .dbg_bgnd_req(dbg_bgnd_req), .cmd_ready(cmd_ready), .op_done(op_done),
  .cond_imask(cond_imask), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
  .mem_win(mem_win), .qfill(qfill), .cpu_clk_en(cpu_clk_en), .bgnd_active(bgnd_active));
`default_nettype wire

// ---- sim/oas_mem.sv ----
// Purpose: Flat 64 KB memory on the sequencer's bus.
// Assumes: Read data is due the cycle after mem_rd.
// Notes: Idle cycles show inverted data so a late capture is caught.
`timescale 1ns/1ps
`default_nettype none
module oas_mem (
  input wire logic clk,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [7:0] mem [0:65535];
  logic [7:0] last;
  // Data stands while mem_rd is up; the sequencer takes it at the next edge
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~last;
  initial begin
    last = 8'h00;
    for (int a = 0; a < 65536; a++) begin
      mem[a] = a[7:0] ^ a[15:8] ^ 8'ha5;
    end
  end
  always @(posedge clk) begin
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
    end
    if (mem_rd) begin
      last <= mem[mem_addr];
    end
  end
endmodule // oas_mem
`default_nettype wire

// ---- sim/oas_seq_tb.sv ----
// Purpose: Self-checking bench for the operand address and exception sequencer.
// Assumes: oas_mem holds the fill pattern and keeps stack writes.
// Notes: Operand bytes are predicted from the bench's own copy of the pattern.
`timescale 1ns/1ps
`default_nettype none
`include "oas_defines.vh"
module oas_seq_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid, cmd_wide, cmd_rel, cmd_cond, dbg_bgnd_req, dbg_go;
  logic reg_wr_hx, reg_wr_sp, reg_wr_ccr, cmd_ready, op_done, cond_imask;
  logic mem_rd, mem_wr, mem_win, qfill, cpu_clk_en, bgnd_active;
  logic [2:0] cmd_op;
  logic [3:0] cmd_mode;
  logic [7:0] irq_req, acc, flags, mem_rdata, mem_wdata, program_page_select, b1, b2;
  logic [15:0] reg_wdata, eff_addr, operand, branch_target, pc, index_pair;
  logic [15:0] stack_pointer, mem_addr, p, hx, stk, ex;
  logic [18:0] notes[$];
  logic [18:0] nt;
  logic [7:0] wq[$];
  logic [15:0] rq[$];
  int miscompares = 0;
  int tests_run = 0;
  int i;

  oas_seq #(.IRQ_N(8)) oas_seq_i (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_mode(cmd_mode), .cmd_wide(cmd_wide), .cmd_rel(cmd_rel),
    .cmd_cond(cmd_cond), .irq_req(irq_req), .dbg_bgnd_req(dbg_bgnd_req), .dbg_go(dbg_go),
    .acc(acc), .flags(flags), .reg_wr_hx(reg_wr_hx), .reg_wr_sp(reg_wr_sp),
    .reg_wr_ccr(reg_wr_ccr), .reg_wdata(reg_wdata), .mem_rdata(mem_rdata),
    .cmd_ready(cmd_ready), .op_done(op_done), .eff_addr(eff_addr), .operand(operand),
    .branch_target(branch_target), .pc(pc), .index_pair(index_pair),
    .stack_pointer(stack_pointer), .program_page_select(program_page_select),
    .cond_imask(cond_imask), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_win(mem_win), .qfill(qfill), .cpu_clk_en(cpu_clk_en),
    .bgnd_active(bgnd_active));
  oas_mem oas_mem_i (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  always #20 clk = ~clk;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'ha5;
  endfunction
  function automatic logic sig(input int n);
    case (n)
      0: return cmd_ready;
      1: return op_done;
      2: return cpu_clk_en;
      default: return bgnd_active;
    endcase
  endfunction
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic await(input int n, input logic v);
    int k;
    k = 0;
    while (sig(n) !== v && k < 400) begin
      step();
      k++;
    end
    if (k >= 400) begin
      miscompares++;
      $display("MISMATCH wait %0d expected %b seen timeout", n, v);
    end
  endtask
  task automatic wait_ready();
    step();
    await(0, 1'b1);
  endtask
  task automatic send(input logic [2:0] o, input logic [3:0] m, input logic w);
    cmd_op = o;
    cmd_mode = m;
    cmd_wide = w;
    cmd_valid = 1'b1;
    step();
    cmd_valid = 1'b0;
  endtask
  task automatic issue(input logic [2:0] o, input logic [3:0] m, input logic w);
    send(o, m, w);
    await(1, 1'b1);
  endtask
  task automatic load(input logic [2:0] which, input logic [15:0] v);
    reg_wdata = v;
    {reg_wr_hx, reg_wr_sp, reg_wr_ccr} = which;
    step();
    {reg_wr_hx, reg_wr_sp, reg_wr_ccr} = 3'b000;
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (5) step();
    rq.delete();
    rst = 1'b0;
    wait_ready();
    chk("vector read", rq[0], 16'hfffe);
    chk("stack_pointer", stack_pointer, 16'h00ff);
    chk("index_pair", index_pair, 16'h0000);
    chk("page", {8'h00, program_page_select}, 16'h0000);
    chk("mask", {15'h0000, cond_imask}, 16'h0001);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Results are popped in the order the driver noted them
  always @(posedge clk) begin
    if (mem_wr === 1'b1) wq.push_back(mem_wdata);
    if (mem_rd === 1'b1) rq.push_back(mem_addr);
    if (op_done === 1'b1 && notes.size() > 0) begin
      nt = notes.pop_front();
      case (nt[18:16])
        3'h0: chk("eff_addr", eff_addr, nt[15:0]);
        3'h1: chk("operand", operand, nt[15:0]);
        3'h2: chk("branch_target", branch_target, nt[15:0]);
        3'h3: chk("page", {8'h00, program_page_select}, nt[15:0]);
        default: chk("stack_pointer", stack_pointer, nt[15:0]);
      endcase
    end
  end

  // Whole run needs a few hundred cycles; the 20000-cycle limit leaves ample margin
  initial begin
    #(40 * 20000);
    miscompares++;
    stop_test();
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    {cmd_valid, cmd_wide, cmd_rel, cmd_cond, dbg_bgnd_req, dbg_go} = 6'h00;
    {reg_wr_hx, reg_wr_sp, reg_wr_ccr} = 3'b000;
    {cmd_op, cmd_mode, irq_req, reg_wdata} = '0;
    i = $urandom(6);
    acc = 8'($urandom);
    flags = 8'($urandom) & 8'hf7;
    do_reset();
    $display("test reset done");
    for (int m = 2; m <= 12; m++) begin
      hx = (m == 6) ? 16'hffff : 16'($urandom);
      stk = 16'($urandom);
      load(3'b100, hx);
      load(3'b010, stk);
      wait_ready();
      p = pc;
      b1 = pat(p);
      b2 = pat(p + 16'h0001);
      case (m)
        2, 4: ex = {b1, b2};
        3, 12: ex = {8'h00, b1};
        5, 6: ex = hx;
        7, 8: ex = hx + b1;
        9: ex = hx + {b1, b2};
        10: ex = stk + b1;
        default: ex = stk + {b1, b2};
      endcase
      notes.push_back({(m == 2) ? 3'h1 : 3'h0, ex});
      cmd_rel = (m == 12);
      issue(`OAS_OP_EA, (m == 12) ? `OAS_M_DIR : 4'(m), m == 2);
      cmd_rel = 1'b0;
      if (m == 6 || m == 8) begin
        wait_ready();
        chk("index_pair", index_pair, hx + 16'h0001);
      end
    end
    $display("test modes done");
    load(3'b010, 16'h00ff);
    wait_ready();
    p = pc;
    b1 = pat(p);
    notes.push_back({3'h2, p + 16'h0001 + {{8{b1[7]}}, b1}});
    cmd_cond = 1'b1;
    issue(`OAS_OP_BRANCH, `OAS_M_REL, 1'b0);
    cmd_cond = 1'b0;
    wait_ready();
    p = pc;
    notes.push_back({3'h3, 8'h00, pat(p + 16'h0002)});
    issue(`OAS_OP_CALL, `OAS_M_EXT, 1'b0);
    wait_ready();
    notes.push_back({3'h3, 16'h0000});
    issue(`OAS_OP_RTC, `OAS_M_INH, 1'b0);
    wait_ready();
    chk("stack_pointer", stack_pointer, 16'h00ff);
    $display("test branch and far call done");
    i = $urandom_range(6, 0);
    irq_req = 8'(1 << i) | 8'h80;
    repeat (20) step();
    chk("ready while masked", {15'h0000, cmd_ready}, 16'h0001);
    wq.delete();
    rq.delete();
    notes.push_back({3'h4, 16'h00fa});
    load(3'b001, 16'h0000);
    await(1, 1'b1);
    irq_req = 8'h00;
    chk("push count", 16'(wq.size()), 16'h0005);
    chk("x push", {8'h00, wq[2]}, {8'h00, hx[7:0]});
    chk("a push", {8'h00, wq[3]}, {8'h00, acc});
    chk("ccr push", {8'h00, wq[4]}, {8'h00, flags});
    ex = 16'hfffa - 16'(2 * i);
    chk("vector hi", rq[0], ex);
    chk("vector lo", rq[1], ex + 16'h0001);
    chk("fill start", rq[2], {pat(ex), pat(ex + 16'h0001)});
    chk("mask", {15'h0000, cond_imask}, 16'h0001);
    wait_ready();
    rq.delete();
    notes.push_back({3'h4, 16'h00f5});
    issue(`OAS_OP_SWI, `OAS_M_INH, 1'b0);
    chk("swi vector", rq[0], 16'hfffc);
    $display("test interrupts done");
    wait_ready();
    send(`OAS_OP_WAIT, `OAS_M_INH, 1'b0);
    await(2, 1'b0);
    chk("mask in wait", {15'h0000, cond_imask}, 16'h0000);
    dbg_bgnd_req = 1'b1;
    await(3, 1'b1);
    chk("clock in background", {15'h0000, cpu_clk_en}, 16'h0001);
    dbg_bgnd_req = 1'b0;
    dbg_go = 1'b1;
    wait_ready();
    dbg_go = 1'b0;
    send(`OAS_OP_WAIT, `OAS_M_INH, 1'b0);
    await(2, 1'b0);
    rq.delete();
    notes.push_back({3'h4, 16'h00f0});
    irq_req = 8'h04;
    await(1, 1'b1);
    irq_req = 8'h00;
    chk("wake vector", rq[0], 16'hfff6);
    $display("test wait done");
    wait_ready();
    send(`OAS_OP_EA, `OAS_M_EXT, 1'b0);
    step();
    do_reset();
    $display("test mid-operation reset done");
    chk("notes left", 16'(notes.size()), 16'h0000);
    stop_test();
  end
endmodule // oas_seq_tb
`default_nettype wire
